// ### rcpm_pkg.sv
// Purpose: shared constants and types of the read channel power mode control
// Assumes: 200 MHz clock, 13 bit serial control word, four latch banks
// Notes:   offsets are byte addresses on the plain register port
package rcpm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RECOVER_NS    = 15000;
  // strictly less than the recovery time, so one cycle short of it
  localparam int unsigned RECOVER_CYC   = RECOVER_NS / CLK_PERIOD_NS - 1;
  localparam int unsigned RCNT_W        = 12;

  localparam int unsigned WORD_BITS = 13;
  localparam int unsigned DATA_BITS = 11;
  localparam int unsigned BANKS     = 4;
  localparam int unsigned BSEL_LSB  = 11;
  localparam int unsigned BCNT_W    = 4;

  // bank (1,0) holds the power-down bits
  localparam logic [1:0] PWR_BANK      = 2'h2;
  localparam int unsigned DET_OFF_POS   = 4;
  localparam int unsigned SYNTH_OFF_POS = 3;
  localparam int unsigned SYNC_OFF_POS  = 2;

  localparam logic [DATA_BITS-1:0] BANK0_DEF = 11'h000;
  localparam logic [DATA_BITS-1:0] BANK1_DEF = 11'h000;
  localparam logic [DATA_BITS-1:0] BANK2_DEF = 11'h01C;
  localparam logic [DATA_BITS-1:0] BANK3_DEF = 11'h000;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_BANK0  = 8'h08;
  localparam logic [7:0] ADDR_BANK1  = 8'h0C;
  localparam logic [7:0] ADDR_BANK2  = 8'h10;
  localparam logic [7:0] ADDR_BANK3  = 8'h14;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam int unsigned CTRL_SLEEP_POS = 0;

  typedef enum logic [1:0] {
    RCPM_ASLEEP = 2'b00,
    RCPM_IDLE   = 2'b01,
    RCPM_WAKING = 2'b10,
    RCPM_SERVO  = 2'b11
  } rcpm_mode_e;

  typedef struct packed {
    logic det_on;     // detector and servo path fully on
    logic det_bias;   // recovery biasing only
    logic reg_on;     // control register powered
    logic reg_buf_on; // register input buffers powered
    logic sync_on;    // data synchronizer powered
    logic synth_on;   // frequency synthesizer powered
  } rcpm_pwr_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rcpm_bus_s;

endpackage

// ### rcpm_power_ctrl.sv
// Purpose: power mode decode, control register latches and serial loading
// Assumes: all pin inputs synchronous to clk; rstn is the supply power-up
// Notes:   enables and status are registered, one cycle after their cause
module rcpm_power_ctrl
  import rcpm_pkg::*;
(
  input  wire logic        clk,                 // 200 MHz clock
  input  wire logic        rstn,                // async reset, active low
  input  wire logic        sleep_pin,           // 0 puts chip to sleep
  input  wire logic        idle_servo_pin,      // 1 idle, 0 servo
  input  wire logic        ser_clk,             // serial shift clock
  input  wire logic        ser_data,            // serial shift data
  input  wire logic        load_shift_strobe,   // high loads, low shifts
  input  wire logic [7:0]  bus_addr,            // register byte address
  input  wire logic [31:0] bus_wdata,           // register write data
  input  wire logic        bus_wr,              // write strobe
  input  wire logic        bus_rd,              // read strobe
  output logic      [31:0] bus_rdata,           // read data, next cycle
  output rcpm_pwr_s        pwr_en,              // per-block power enables
  output logic             det_ready,           // detector recovered
  output logic             switched_supply_out, // switched supply on
  output logic [DATA_BITS-1:0] data_sync_bank,  // bank (1,0) contents
  output logic             word_valid,          // full word shifted
  output logic             blind_load           // load before valid word
);

  rcpm_bus_s             bus;
  logic [31:0]           ctrl_r;
  logic                  awake;
  logic                  awake_r;
  logic                  wake_edge;
  logic [DATA_BITS-1:0]  bank_r [BANKS];
  logic [WORD_BITS-1:0]  shift_r;
  logic [BCNT_W-1:0]     bit_cnt_r;
  logic                  ser_clk_r;
  logic                  strobe_r;
  logic                  shift_edge;
  logic                  load_edge;
  logic                  buf_on;
  rcpm_pwr_s             pwr_nxt;
  rcpm_mode_e            mode_r;
  rcpm_mode_e            mode_nxt;
  logic [RCNT_W-1:0]     rcnt_r;
  logic [31:0]           rdata_nxt;
  logic                  det_off_bit;
  logic                  data_sync_off_bit;
  logic                  freq_synth_off_bit;

  // selective power-down decode, shared by the enables and the status
  function automatic rcpm_pwr_s pwr_decode(
    input logic sleep_n,
    input logic idle,
    input logic det_off,
    input logic sync_off,
    input logic synth_off
  );
    rcpm_pwr_s p;
    p = '0;
    if (sleep_n) begin
      p.reg_on     = 1'b1;
      p.reg_buf_on = !idle && !det_off;
      p.det_on     = !idle && !det_off;
      p.det_bias   = idle && !det_off;
      p.sync_on    = !sync_off;
      p.synth_on   = !synth_off;
    end
    return p;
  endfunction

  function automatic logic [DATA_BITS-1:0] bank_default(input int unsigned i);
    logic [DATA_BITS-1:0] v;
    v = BANK0_DEF;
    if (i == 1) begin
      v = BANK1_DEF;
    end else if (i == 2) begin
      v = BANK2_DEF;
    end else if (i == 3) begin
      v = BANK3_DEF;
    end
    return v;
  endfunction

  assign bus.addr  = bus_addr;
  assign bus.wdata = bus_wdata;
  assign bus.wr    = bus_wr;
  assign bus.rd    = bus_rd;

  // software sleep request can only add sleep, never lift the pin's sleep
  assign awake = sleep_pin && !ctrl_r[CTRL_SLEEP_POS];

  assign det_off_bit        = bank_r[PWR_BANK][DET_OFF_POS];
  assign data_sync_off_bit  = bank_r[PWR_BANK][SYNC_OFF_POS];
  assign freq_synth_off_bit = bank_r[PWR_BANK][SYNTH_OFF_POS];

  always_comb begin
    pwr_nxt = pwr_decode(awake, idle_servo_pin, det_off_bit,
                         data_sync_off_bit, freq_synth_off_bit);
  end

  // loads refused while asleep or idle; gating on bit 4 too would lock the
  // power-up defaults in for good, since they hold the detector off
  assign buf_on     = awake && !idle_servo_pin;
  assign wake_edge  = awake && !awake_r;
  assign shift_edge = ser_clk && !ser_clk_r && !load_shift_strobe && buf_on;
  assign load_edge  = load_shift_strobe && !strobe_r && buf_on;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
    end else if (bus.wr && bus.addr == ADDR_CTRL) begin
      ctrl_r <= {31'h0000_0000, bus.wdata[CTRL_SLEEP_POS]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awake_r   <= 1'b0;
      ser_clk_r <= 1'b0;
      strobe_r  <= 1'b0;
    end else begin
      awake_r   <= awake;
      ser_clk_r <= ser_clk;
      strobe_r  <= load_shift_strobe;
    end
  end

  // serial shift register; asleep it loses power, so the count restarts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_r   <= '0;
      bit_cnt_r <= '0;
    end else if (!awake) begin
      bit_cnt_r <= '0;
    end else if (shift_edge) begin
      shift_r <= {shift_r[WORD_BITS-2:0], ser_data};
      if (bit_cnt_r < BCNT_W'(WORD_BITS)) begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_valid <= 1'b0;
    end else begin
      word_valid <= awake && (bit_cnt_r >= BCNT_W'(WORD_BITS));
    end
  end

  // flags a strobe that landed on an undefined word; cleared on next wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blind_load <= 1'b0;
    end else if (load_edge && bit_cnt_r < BCNT_W'(WORD_BITS)) begin
      blind_load <= 1'b1;
    end else if (wake_edge) begin
      blind_load <= 1'b0;
    end
  end

  // latch banks: preset while asleep so the wake cycle sees defaults
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_r[i] <= bank_default(i);
      end
    end else if (!awake) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_r[i] <= bank_default(i);
      end
    end else if (load_edge) begin
      // an unshifted word still names some bank, matching the random load
      bank_r[shift_r[WORD_BITS-1:BSEL_LSB]] <= shift_r[DATA_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_en              <= '0;
      switched_supply_out <= 1'b0;
      data_sync_bank      <= BANK2_DEF;
    end else begin
      pwr_en              <= pwr_nxt;
      switched_supply_out <= awake;
      data_sync_bank      <= bank_r[PWR_BANK];
    end
  end

  // detector mode tracking with the recovery window after idle
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      RCPM_ASLEEP: begin
        if (awake) begin
          mode_nxt = RCPM_IDLE;
        end
      end
      RCPM_IDLE: begin
        if (!awake) begin
          mode_nxt = RCPM_ASLEEP;
        end else if (pwr_nxt.det_on) begin
          mode_nxt = RCPM_WAKING;
        end
      end
      RCPM_WAKING: begin
        if (!awake) begin
          mode_nxt = RCPM_ASLEEP;
        end else if (!pwr_nxt.det_on) begin
          mode_nxt = RCPM_IDLE;
        end else if (rcnt_r >= RCNT_W'(RECOVER_CYC - 1)) begin
          mode_nxt = RCPM_SERVO;
        end
      end
      RCPM_SERVO: begin
        if (!awake) begin
          mode_nxt = RCPM_ASLEEP;
        end else if (!pwr_nxt.det_on) begin
          mode_nxt = RCPM_IDLE;
        end
      end
      default: begin
        mode_nxt = RCPM_ASLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= RCPM_ASLEEP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rcnt_r <= '0;
    end else if (mode_r == RCPM_WAKING) begin
      rcnt_r <= rcnt_r + 1'b1;
    end else begin
      rcnt_r <= '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_ready <= 1'b0;
    end else begin
      det_ready <= (mode_nxt == RCPM_SERVO);
    end
  end

  // register read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus.addr == ADDR_STATUS) begin
      rdata_nxt = {20'h00000, blind_load, word_valid, mode_r,
                   det_ready, switched_supply_out, pwr_en};
    end else if (bus.addr == ADDR_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (bus.addr == ADDR_BANK0) begin
      rdata_nxt = {21'h000000, bank_r[0]};
    end else if (bus.addr == ADDR_BANK1) begin
      rdata_nxt = {21'h000000, bank_r[1]};
    end else if (bus.addr == ADDR_BANK2) begin
      rdata_nxt = {21'h000000, bank_r[2]};
    end else if (bus.addr == ADDR_BANK3) begin
      rdata_nxt = {21'h000000, bank_r[3]};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ### rcpm_power_ctrl_sva.sv
// Purpose: port level checks of the power mode control
// Assumes: one clock domain, rstn async active low
// Notes:   bound from the testbench top file
module rcpm_power_ctrl_sva
  import rcpm_pkg::*;
(
  input wire logic                 clk,                 // clock
  input wire logic                 rstn,                // reset, active low
  input wire logic                 sleep_pin,           // 0 = sleep
  input wire logic                 idle_servo_pin,      // 1 = idle
  input wire rcpm_pwr_s            pwr_en,              // block enables
  input wire logic                 det_ready,           // detector recovered
  input wire logic                 switched_supply_out, // switched supply
  input wire logic [DATA_BITS-1:0] data_sync_bank,      // bank (1,0)
  input wire logic                 word_valid           // full word in
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles the detector has been requested on without being ready
  int unsigned          wait_cyc;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_cyc <= 0;
    end else if (pwr_en.det_on && !det_ready) begin
      wait_cyc <= wait_cyc + 1;
    end else begin
      wait_cyc <= 0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence asleep_2;
    !sleep_pin ##1 !sleep_pin;
  endsequence
  a_sleep_all_off: assert property (!sleep_pin |=> pwr_en == '0)
    else $error("enable left on in sleep");
  a_supply_low_sleep: assert property (!sleep_pin |=> !switched_supply_out)
    else $error("switched supply high in sleep");
  a_reg_follows_sleep: assert property (pwr_en.reg_on |-> $past(sleep_pin))
    else $error("register powered without sleep pin high");
  a_sync_follows_bit: assert property (pwr_en.sync_on |-> !data_sync_bank[SYNC_OFF_POS])
    else $error("synchronizer on with its off bit set");
  a_synth_follows_bit: assert property (pwr_en.synth_on |-> !data_sync_bank[SYNTH_OFF_POS])
    else $error("synthesizer on with its off bit set");
  a_det_off_bit: assert property (data_sync_bank[DET_OFF_POS] |-> !pwr_en.det_on && !pwr_en.det_bias)
    else $error("detector or bias on with its off bit set");
  a_idle_no_det: assert property (idle_servo_pin |=> !pwr_en.det_on)
    else $error("detector fully on in idle");
  a_wake_defaults: assert property (asleep_2 |=> data_sync_bank == BANK2_DEF)
    else $error("bank not at default after sleep");
  a_det_recovers: assert property (wait_cyc < RECOVER_NS / CLK_PERIOD_NS)
    else $error("detector recovery too slow");
  a_word_cleared: assert property (!sleep_pin |=> !word_valid)
    else $error("word valid kept through sleep");
endmodule

// ### rcpm_ctrl_model.sv
// Purpose: disk controller side, shifts control words and pulses the strobe
// Assumes: bench clock, requests change just after a rising edge
// Notes:   two cycles per bit so each shift clock rise is seen once
module rcpm_ctrl_model
  import rcpm_pkg::*;
(
  input wire logic clk,               // bench clock
  output logic     ser_clk,           // shift clock
  output logic     ser_data,          // shift data
  output logic     load_shift_strobe  // rising edge loads
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_shift_strobe = 1'b0;
  end
  // blind skips the shifting to provoke an early load
  task automatic send(input logic [WORD_BITS-1:0] word, input bit blind);
    if (!blind) begin
      for (int i = WORD_BITS - 1; i >= 0; i--) begin
        @(posedge clk);
        ser_clk <= 1'b0;
        ser_data <= word[i];
        @(posedge clk);
        ser_clk <= 1'b1;
      end
    end
    @(posedge clk);
    ser_clk <= 1'b0;
    ser_data <= ~ser_data; // released line must not hold the last bit
    load_shift_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    load_shift_strobe <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ### test_rcpm_power_ctrl.sv
// Purpose: self-checking bench of the power mode control
// Assumes: controller model drives the serial pins, bench drives mode pins
// Notes:   mode pins change 1 ns after an edge, serial and bus pins and idle after the t_recover send on it; outputs are read 1 ns after one
module test_rcpm_power_ctrl
  import rcpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, sleep_pin = 1'b1, idle_servo_pin = 1'b0;
  logic bus_wr = 1'b0, bus_rd = 1'b0, ser_clk, ser_data, load_shift_strobe;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, rd;
  rcpm_pwr_s pwr_en;
  logic det_ready, switched_supply_out, word_valid, blind_load;
  logic [DATA_BITS-1:0] data_sync_bank;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  rcpm_power_ctrl dut (.clk, .rstn, .sleep_pin, .idle_servo_pin, .ser_clk, .ser_data, .load_shift_strobe,
    .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .pwr_en, .det_ready, .switched_supply_out,
    .data_sync_bank, .word_valid, .blind_load);
  rcpm_ctrl_model u_ctrl (.clk, .ser_clk, .ser_data, .load_shift_strobe);
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic bus_read(input logic [7:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 rd = bus_rdata;
  endtask
  // b = {detector, synthesizer, synchronizer} off bits; buffers off in idle or with bit 4
  task automatic check_pwr(input logic [2:0] b);
    logic [5:0] e;
    e = {~b[2] & ~idle_servo_pin, ~b[2] & idle_servo_pin, 1'b1, ~b[2] & ~idle_servo_pin, ~b[0], ~b[1]};
    chk("pwr_en", 32'(e), 32'(pwr_en));
  endtask
  task automatic t_powerup();
    ticks(2);
    check_pwr(3'b111);
    chk("bank", 32'(BANK2_DEF), 32'(data_sync_bank));
    chk("supply", 32'h1, 32'(switched_supply_out));
  endtask
  task automatic t_decode();
    logic [2:0] b;
    for (int k = 0; k < 8; k++) begin
      b = 3'(k);
      u_ctrl.send({2'b10, 6'h00, b, 2'b00}, 1'b0);
      ticks(2);
      chk("bank", 32'({6'h00, b, 2'b00}), 32'(data_sync_bank));
      check_pwr(b);
      idle_servo_pin <= 1'b1;
      ticks(2);
      check_pwr(b);
      u_ctrl.send({2'b10, ~{6'h00, b, 2'b00}}, 1'b0);
      ticks(2);
      chk("bank", 32'({6'h00, b, 2'b00}), 32'(data_sync_bank));
      idle_servo_pin <= 1'b0;
      ticks(2);
      chk("bank", 32'({6'h00, b, 2'b00}), 32'(data_sync_bank));
    end
  endtask
  task automatic t_recover();
    int n;
    u_ctrl.send({2'b10, 11'h00C}, 1'b0);
    idle_servo_pin <= 1'b1;
    ticks(4);
    chk("det_ready", 32'h0, 32'(det_ready));
    idle_servo_pin <= 1'b0;
    n = 0;
    while (det_ready !== 1'b1 && n < RECOVER_NS / CLK_PERIOD_NS) begin
      ticks(1);
      n++;
    end
    chk("det_ready", 32'h1, 32'(det_ready));
    check_pwr(3'b011);
  endtask
  task automatic t_sleep();
    sleep_pin <= 1'b0;
    ticks(3);
    chk("pwr_en", 32'h0, 32'(pwr_en));
    chk("supply", 32'h0, 32'(switched_supply_out));
    sleep_pin <= 1'b1;
    ticks(2);
    chk("bank", 32'(BANK2_DEF), 32'(data_sync_bank));
    chk("word_valid", 32'h0, 32'(word_valid));
    check_pwr(3'b111);
    u_ctrl.send(13'h0000, 1'b1);
    ticks(2);
    chk("blind_load", 32'h1, 32'(blind_load));
    u_ctrl.send({2'b10, 11'h5A0}, 1'b0);
    ticks(2);
    chk("word_valid", 32'h1, 32'(word_valid));
    chk("bank", 32'h5A0, 32'(data_sync_bank));
  endtask
  task automatic t_regbus();
    bus_read(ADDR_BANK2);
    chk("bank read", 32'h5A0, rd);
    bus_read(8'h40);
    chk("unmapped read", 32'h0, rd);
    bus_write(ADDR_CTRL, 32'h1);
    ticks(3);
    chk("pwr_en", 32'h0, 32'(pwr_en));
    bus_write(ADDR_CTRL, 32'h0);
    ticks(3);
    chk("bank", 32'(BANK2_DEF), 32'(data_sync_bank));
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_powerup();
    t_decode();
    t_recover();
    t_sleep();
    t_regbus();
    tally_and_finish();
  end
endmodule
bind rcpm_power_ctrl rcpm_power_ctrl_sva u_sva (.clk, .rstn, .sleep_pin, .idle_servo_pin, .pwr_en, .det_ready,
  .switched_supply_out, .data_sync_bank, .word_valid);
